// ===== rtl/expb_simplex_pkg.sv
// Purpose: Shared constants for the simplex expansion-bus access sequencer
// Assumes: 50 MHz core clock, phase lengths in whole clock cycles
// Notes: Phase length fields hold (cycles - 1)
package expb_simplex_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int LEN2_W = 2;
    localparam int LEN4_W = 4;
    localparam logic [LEN2_W-1:0] LEN2_RST = 2'h3;
    localparam logic [LEN4_W-1:0] LEN4_RST = 4'hf;
    localparam int CNT_W = 4;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ADDR    = 6'h02,
        ST_SETUP   = 6'h04,
        ST_STROBE  = 6'h08,
        ST_HOLD    = 6'h10,
        ST_RECOV   = 6'h20
    } phase_e;
endpackage : expb_simplex_pkg

// ===== rtl/phase_counter.sv
// Purpose: Down counter that times one access phase
// Assumes: Load value is the phase length minus one
// Notes: o_last is high in the final cycle of the phase
`timescale 1ns/100ps
module phase_counter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_load,
    input wire logic [expb_simplex_pkg::CNT_W-1:0] i_value,
    // Status
    output logic o_last
);
    import expb_simplex_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // Reload on phase entry, otherwise count towards zero
    always_comb begin
        if (i_load) begin
            next_count = i_value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_last = (count == '0);
endmodule : phase_counter

// ===== rtl/expb_simplex_seq.sv
// Purpose: Simplex-mode expansion bus access sequencer, bus master side
// Assumes: Phase lengths are stable while an access runs
// Notes: Operation
`timescale 1ns/100ps
module expb_simplex_seq (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Phase lengths, value is cycles minus one
    input wire logic [expb_simplex_pkg::LEN2_W-1:0] i_address_phase_length,
    input wire logic [expb_simplex_pkg::LEN2_W-1:0] i_data_setup_phase_length,
    input wire logic [expb_simplex_pkg::LEN4_W-1:0] i_strobe_phase_length,
    input wire logic [expb_simplex_pkg::LEN2_W-1:0] i_hold_phase_length,
    input wire logic [expb_simplex_pkg::LEN4_W-1:0] i_recovery_phase_length,
    // Access request
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [expb_simplex_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [expb_simplex_pkg::DATA_W-1:0] i_req_wdata,
    output logic o_req_ready,
    // Read answer
    output logic o_rd_valid,
    output logic [expb_simplex_pkg::DATA_W-1:0] o_rd_data,
    // Expansion bus pins
    output logic o_cs_low,
    output logic o_bus_write_strobe_low,
    output logic o_periph_read_strobe_low,
    output logic o_ale,
    output logic [expb_simplex_pkg::ADDR_W-1:0] o_addr,
    output logic [expb_simplex_pkg::DATA_W-1:0] o_data_out,
    output logic o_data_oe,
    input wire logic [expb_simplex_pkg::DATA_W-1:0] i_data_in
);
    import expb_simplex_pkg::*;

    // ************************************************************
    // State and registers
    // ************************************************************
    phase_e state;
    phase_e next_state;
    logic is_write;
    logic next_is_write;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic rd_valid;
    logic next_rd_valid;
    logic rd_arm;
    logic next_rd_arm;
    logic rd_take;
    logic next_rd_take;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic cnt_last;

    // Widen a two-bit length to the counter width
    function automatic logic [CNT_W-1:0] widen2(input logic [LEN2_W-1:0] v);
        widen2 = {{(CNT_W-LEN2_W){1'b0}}, v};
    endfunction : widen2

    // ************************************************************
    // Phase timer
    // ************************************************************
    phase_counter u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(cnt_load),
        .i_value(cnt_value),
        .o_last(cnt_last)
    );

    // Read data pins cross from the pad, two stages before use
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            din_s1 <= i_data_in;
            din_s2 <= din_s1;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Each phase except recovery reloads the timer for the phase that follows
    always_comb begin
        next_state = state;
        next_is_write = is_write;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_rd_valid = 1'b0;
        cnt_load = 1'b0;
        cnt_value = '0;
        unique case (state)
            ST_IDLE: begin
                if (i_req_valid) begin
                    next_state = ST_ADDR;
                    next_is_write = i_req_write;
                    next_addr = i_req_addr;
                    next_wdata = i_req_wdata;
                    cnt_load = 1'b1;
                    cnt_value = widen2(i_address_phase_length);
                end
            end
            ST_ADDR: begin
                if (cnt_last) begin
                    next_state = ST_SETUP;
                    cnt_load = 1'b1;
                    cnt_value = widen2(i_data_setup_phase_length);
                end
            end
            ST_SETUP: begin
                if (cnt_last) begin
                    next_state = ST_STROBE;
                    cnt_load = 1'b1;
                    cnt_value = i_strobe_phase_length;
                end
            end
            ST_STROBE: begin
                if (cnt_last) begin
                    next_state = ST_HOLD;
                    cnt_load = 1'b1;
                    cnt_value = widen2(i_hold_phase_length);
                end
            end
            ST_HOLD: begin
                if (cnt_last) begin
                    next_state = ST_RECOV;
                    cnt_load = 1'b1;
                    cnt_value = i_recovery_phase_length;
                end
            end
            ST_RECOV: begin
                if (cnt_last) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Mark the last read strobe cycle; the pad sync delays that pin value by
        // two cycles, so the capture lands in hold or recovery whatever the lengths
        next_rd_arm = (state == ST_STROBE) && cnt_last && !is_write;
        next_rd_take = rd_arm;
        if (rd_take) begin
            next_rdata = din_s2;
            next_rd_valid = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            is_write <= 1'b0;
            addr <= '0;
            wdata <= '0;
            rdata <= '0;
            rd_valid <= 1'b0;
            rd_arm <= 1'b0;
            rd_take <= 1'b0;
        end else begin
            state <= next_state;
            is_write <= next_is_write;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            rd_valid <= next_rd_valid;
            rd_arm <= next_rd_arm;
            rd_take <= next_rd_take;
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Select spans setup through hold, address spans the whole access, write data is driven from address through hold
    assign o_cs_low = !(state inside {ST_SETUP, ST_STROBE, ST_HOLD});
    assign o_bus_write_strobe_low = !(state == ST_STROBE && is_write);
    assign o_periph_read_strobe_low = !(state == ST_STROBE && !is_write);
    assign o_ale = 1'b0;
    assign o_addr = addr;
    assign o_data_out = wdata;
    assign o_data_oe = is_write && (state inside {ST_ADDR, ST_SETUP, ST_STROBE, ST_HOLD});
    assign o_req_ready = (state == ST_IDLE);
    assign o_rd_valid = rd_valid;
    assign o_rd_data = rdata;

    // ************************************************************
    // Checks
    // ************************************************************
    phase_cs_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_ADDR) |-> o_cs_low) else $error("select active in address phase");
    addr_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_IDLE && i_req_valid && i_address_phase_length == 2'h0)
        |=> (state == ST_ADDR) ##1 (state == ST_SETUP)) else $error("address phase length");
    setup_data_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_bus_write_strobe_low) |-> $past(o_data_oe) && $stable(o_data_out))
        else $error("write data not set up");
    strobe_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($fell(o_bus_write_strobe_low) && i_strobe_phase_length == 4'h1)
        |-> !o_bus_write_strobe_low ##1 !o_bus_write_strobe_low ##1 o_bus_write_strobe_low)
        else $error("strobe width wrong");
    hold_data_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_bus_write_strobe_low) |-> o_data_oe && !o_cs_low && $stable(o_data_out))
        else $error("write data dropped after strobe");
    hold_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_HOLD && $past(state) == ST_HOLD) |-> $stable(o_addr) && $stable(o_cs_low))
        else $error("hold phase changed");
    recov_gap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_cs_low) |-> !o_req_ready && o_cs_low ##1 o_cs_low)
        else $error("no recovery gap");
    read_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_periph_read_strobe_low) |-> ##2 o_rd_valid)
        else $error("read word not captured");
    no_ale_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_ale) else $error("address latch pulsed");
    order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state == ST_STROBE && $past(state) != ST_STROBE) |-> $past(state) == ST_SETUP)
        else $error("phase order broken");
endmodule : expb_simplex_seq

// ===== verification/periph_model.sv
// Purpose: Peripheral answering reads on the bus
// Assumes: Strobe sampled at the falling edge
// Notes: Released bus shows the inverse of the read word
`timescale 1ns/100ps
module periph_model #(
    parameter logic [15:0] KEY = 16'h5a3c
) (
    input wire logic i_clk,
    input wire logic i_read_strobe_low,
    input wire logic [expb_simplex_pkg::ADDR_W-1:0] i_addr,
    output logic [expb_simplex_pkg::DATA_W-1:0] o_data
);
    // **********
    // Bus drive
    // **********
    initial o_data = 16'h0000;
    // Inverse when released, so a capture outside the strobe can never pass
    always @(negedge i_clk) begin
        if (!i_read_strobe_low) begin
            o_data <= i_addr[15:0] ^ KEY;
        end else begin
            o_data <= ~(i_addr[15:0] ^ KEY);
        end
    end
endmodule : periph_model

// ===== verification/expb_simplex_seq_tb.sv
// Purpose: Self-checking bench for the access sequencer
// Assumes: Lengths held while an access runs
// Notes: Phases measured from pins at falling edges
`timescale 1ns/100ps
module expb_simplex_seq_tb;
    import expb_simplex_pkg::*;
    localparam logic [DATA_W-1:0] KEY = 16'h5a3c;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [13:0] cfg = '0;
    logic vld = 1'b0;
    logic wr = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic [DATA_W-1:0] wd = '0;
    logic rdy, rdv, cs, wsl, rsl, ale, oe;
    logic [DATA_W-1:0] rdd, dout, din;
    logic [ADDR_W-1:0] aout;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #10 i_clk = ~i_clk;
    expb_simplex_seq DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_address_phase_length(cfg[13:12]), .i_data_setup_phase_length(cfg[11:10]),
        .i_strobe_phase_length(cfg[9:6]), .i_hold_phase_length(cfg[5:4]),
        .i_recovery_phase_length(cfg[3:0]), .i_req_valid(vld), .i_req_write(wr),
        .i_req_addr(adr), .i_req_wdata(wd), .o_req_ready(rdy), .o_rd_valid(rdv),
        .o_rd_data(rdd), .o_cs_low(cs), .o_bus_write_strobe_low(wsl),
        .o_periph_read_strobe_low(rsl), .o_ale(ale), .o_addr(aout),
        .o_data_out(dout), .o_data_oe(oe), .i_data_in(din));
    periph_model #(.KEY(KEY)) PEER (.i_clk(i_clk), .i_read_strobe_low(rsl),
        .i_addr(aout), .o_data(din));
    // **********
    // Checking
    // **********
    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    task automatic chk_n(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fail_count++;
            $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
        end
    endtask : chk_n
    task automatic chk_v(input logic [43:0] got, input logic [43:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: pins %h not %h", $time, got, exp);
        end
    endtask : chk_v
    // One access; cycles classed by select and strobes
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [13:0] c);
        int n[5];
        int p, k, g, pulses;
        logic [DATA_W-1:0] got;
        n = '{default: 0};
        k = 0;
        g = 0;
        pulses = 0;
        got = '0;
        @(posedge i_clk);
        cfg <= c;
        {vld, wr, adr, wd} <= {1'b1, w, a, d};
        @(posedge i_clk);
        vld <= 1'b0;
        @(negedge i_clk);
        while (rdy !== 1'b1 && g < 80) begin
            p = (cs !== 1'b0) ? (k >= 2 ? 4 : 0) : ((wsl & rsl) !== 1'b0 ? (k >= 2 ? 3 : 1) : 2);
            n[p]++;
            k = p;
            chk_v({ale, aout, oe & ~w, wsl | w, rsl | ~w}, {1'b0, a, 3'b011});
            if (p < 4 && w) chk_v({oe, dout}, {1'b1, d});
            if (rdv === 1'b1) begin
                pulses++;
                got = rdd;
            end
            g++;
            @(negedge i_clk);
        end
        // A capture late in a short tail shows in the first idle cycle
        if (rdv === 1'b1) begin
            pulses++;
            got = rdd;
        end
        chk_n(n[0], int'(c[13:12]) + 1);
        chk_n(n[1], int'(c[11:10]) + 1);
        chk_n(n[2], int'(c[9:6]) + 1);
        chk_n(n[3], int'(c[5:4]) + 1);
        chk_n(n[4], int'(c[3:0]) + 1);
        chk_n(pulses, int'(!w));
        if (!w) chk_v(got, a[15:0] ^ KEY);
    endtask : access
    // **********
    // Scenarios
    // **********
    task automatic t_write_min;
        access(1'b1, 24'h000001, 16'hffff, 14'h0000);
    endtask : t_write_min
    task automatic t_write_max;
        access(1'b1, 24'hffffff, 16'h8001, 14'h3fff);
    endtask : t_write_max
    task automatic t_write_mix;
        access(1'b1, 24'h5aa5c3, 16'h1234, {2'h2, 2'h0, 4'h5, 2'h2, 4'h0});
    endtask : t_write_mix
    task automatic t_read_short;
        access(1'b0, 24'h123456, 16'h0000, {2'h1, 2'h2, 4'h0, 2'h0, 4'h7});
    endtask : t_read_short
    task automatic t_read_long;
        access(1'b0, 24'h00fedc, 16'hffff, {2'h3, 2'h0, 4'hf, 2'h0, 4'h0});
    endtask : t_read_long
    task automatic t_write_two;
        access(1'b1, 24'h0c0c0c, 16'h5555, {2'h1, 2'h1, 4'h1, 2'h1, 4'h1});
    endtask : t_write_two
    task automatic t_read_hold;
        access(1'b0, 24'habcdef, 16'h0000, {2'h0, 2'h3, 4'h0, 2'h3, 4'h0});
    endtask : t_read_hold
    // Hang guard, far above the under two hundred cycles needed
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (7) @(posedge i_clk);
        @(negedge i_clk);
        chk_v({rdy, cs, wsl, rsl, oe, ale, rdv}, 44'h78);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_write_min();
        t_write_max();
        t_write_mix();
        t_read_short();
        t_read_long();
        t_write_two();
        t_read_hold();
        summarize();
    end
endmodule : expb_simplex_seq_tb
